/* verilog/vdid_defines.svh */
// Purpose: Offsets, field positions and reset values of the video DAC input decoder
// Assumes: 32-bit Avalon-MM word addressing in bytes
// Notes: Definitions only
`ifndef VDID_DEFINES_SVH
`define VDID_DEFINES_SVH

`define VDID_CODE_W 8
`define VDID_THERM_W 15
`define VDID_LSB_W 4
`define VDID_ADDR_W 4

`define VDID_OFS_CTRL 4'h0
`define VDID_OFS_STATUS 4'h4
`define VDID_OFS_COUNT 4'h8

`define VDID_CTRL_FREEZE 0
`define VDID_CTRL_RST 32'h0000_0000

`define VDID_ST_CODE_LO 0
`define VDID_ST_CODE_HI 7
`define VDID_ST_SYNC 8
`define VDID_ST_BLANK 9
`define VDID_ST_FULL 10
`define VDID_ST_HIGH 11
`define VDID_ST_BYPASS 12

`define VDID_FULL_CODE 8'hff
`define VDID_ZERO_CODE 8'h00
`define VDID_ACCEPT_GRADE_A_MSPS 275
`define VDID_ACCEPT_GRADE_B_MSPS 165

`endif

/* verilog/vdid_pkg.sv */
// Purpose: Types shared by the video DAC input decoder
// Assumes: Constants come from vdid_defines.svh
// Notes: Types only
`include "vdid_defines.svh"

package vdid_pkg;

  typedef logic [`VDID_CODE_W-1:0] vdid_code_t;
  typedef logic [`VDID_THERM_W-1:0] vdid_therm_t;
  typedef logic [`VDID_LSB_W-1:0] vdid_lsb_t;

endpackage : vdid_pkg

/* verilog/vdid_decoder.sv */
// Purpose: Pixel and video control front end driving the DAC current sinks
// Assumes: Pins are asynchronous to sys_clk and sampled through two flip-flops
// Notes: Sample clock is oversampled by sys_clk; only slow pixel rates are seen
//
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`include "vdid_defines.svh"

module vdid_decoder (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] pixel_code,
  input wire logic sample_clock_pair_p,
  input wire logic sample_clock_pair_n,
  input wire logic register_bypass,
  input wire logic sync_in,
  input wire logic blank_in,
  input wire logic force_full_scale,
  input wire logic highlight_boost,
  output logic [14:0] therm_sink_en,
  output logic [3:0] lsb_switch_en,
  output logic sync_sink_en,
  output logic blank_sink_en,
  output logic highlight_sink_en,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // Pin synchronisers; the clock pair is combined only after both stages
  logic [7:0] code_s2;
  logic [6:0] ctl_s2;
  logic [6:0] pins;
  logic clk_prev;
  assign pins = {sample_clock_pair_p, sample_clock_pair_n, register_bypass, sync_in, blank_in,
                 force_full_scale, highlight_boost};

  vdid_sync2 #(
    .WIDTH(8)
  ) u_code_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .d(pixel_code),
    .q(code_s2)
  );

  vdid_sync2 #(
    .WIDTH(7)
  ) u_ctl_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .d(pins),
    .q(ctl_s2)
  );

  // Previous sampled clock level, for rising-edge detection
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      clk_prev <= 1'b0;
    end
    else
    begin
      clk_prev <= ctl_s2[6] & ~ctl_s2[5];
    end
  end

  logic s_clk;
  logic s_bypass;
  logic s_sync;
  logic s_blank;
  logic s_full;
  logic s_high;
  logic sample_edge;
  assign s_clk = ctl_s2[6] & ~ctl_s2[5];
  assign s_bypass = ctl_s2[4];
  assign s_sync = ctl_s2[3];
  assign s_blank = ctl_s2[2];
  assign s_full = ctl_s2[1];
  assign s_high = ctl_s2[0];
  // Data and clock share synchroniser depth, so the edge meets its own pixel
  assign sample_edge = s_clk & ~clk_prev;

  // Control register
  logic [31:0] ctrl;
  logic freeze;
  assign freeze = ctrl[`VDID_CTRL_FREEZE];

  // Priority resolution and decode
  vdid_pkg::vdid_code_t eff_code;
  vdid_pkg::vdid_therm_t next_therm;
  vdid_pkg::vdid_lsb_t next_lsb;
  logic next_sync;
  logic next_blank;
  logic next_high;

  always_comb
  begin
    if (s_sync)
    begin
      eff_code = `VDID_ZERO_CODE;
    end
    else if (s_blank)
    begin
      eff_code = `VDID_ZERO_CODE;
    end
    else if (s_full)
    begin
      eff_code = `VDID_FULL_CODE;
    end
    else
    begin
      eff_code = code_s2;
    end
    // Sync level includes the blank current below it
    next_sync = s_sync;
    next_blank = s_sync | s_blank;
    // Highlight stays on over forced full scale: enhanced high
    next_high = s_high & ~s_sync & ~s_blank;
    for (int i = 0; i < `VDID_THERM_W; i++)
    begin
      next_therm[i] = (32'(eff_code[7:4]) > i);
    end
    // Weights 1,2,4,8 of a unit sink sum to 15, one unit below a thermometer sink of 16
    next_lsb = eff_code[3:0];
  end

  // Output register; transparent path refreshes every cycle while freeze is clear
  // Transparent mode still crosses the synchroniser, so it lags three cycles
  logic load;
  assign load = ~freeze & (s_bypass | sample_edge);

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      therm_sink_en <= 15'h0000;
      lsb_switch_en <= 4'h0;
    end
    else if (load)
    begin
      therm_sink_en <= next_therm;
      lsb_switch_en <= next_lsb;
    end
  end

  // Same strobe as the code sinks, so a control never lands on a neighbour pixel
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync_sink_en <= 1'b0;
      blank_sink_en <= 1'b0;
      highlight_sink_en <= 1'b0;
    end
    else if (load)
    begin
      sync_sink_en <= next_sync;
      blank_sink_en <= next_blank;
      highlight_sink_en <= next_high;
    end
  end

  // Captured pixel and control snapshot for software
  logic [7:0] held_code;
  logic [3:0] held_ctl;
  logic [31:0] sample_count;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      held_code <= 8'h00;
      held_ctl <= 4'h0;
    end
    else if (load)
    begin
      held_code <= code_s2;
      held_ctl <= {s_high, s_full, s_blank, s_sync};
    end
  end

  // Counts registered loads only; wraps silently
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sample_count <= 32'h0000_0000;
    end
    else if (load && !s_bypass)
    begin
      sample_count <= sample_count + 32'h0000_0001;
    end
  end

  // Avalon-MM slave: one wait cycle, then accept
  logic ack;
  logic req;
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ack <= 1'b0;
    end
    else
    begin
      ack <= req & ~ack;
    end
  end

  logic [31:0] status_word;
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[`VDID_ST_CODE_HI:`VDID_ST_CODE_LO] = held_code;
    status_word[`VDID_ST_SYNC] = held_ctl[0];
    status_word[`VDID_ST_BLANK] = held_ctl[1];
    status_word[`VDID_ST_FULL] = held_ctl[2];
    status_word[`VDID_ST_HIGH] = held_ctl[3];
    // Live pin level, not the captured one
    status_word[`VDID_ST_BYPASS] = s_bypass;
  end

  // Captured in the wait cycle, so it already stands at the accept edge
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      avs_readdata <= 32'h0000_0000;
    end
    else if (avs_read && !ack)
    begin
      case (avs_address)
        `VDID_OFS_CTRL: avs_readdata <= ctrl;
        `VDID_OFS_STATUS: avs_readdata <= status_word;
        `VDID_OFS_COUNT: avs_readdata <= sample_count;
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Write lands at the accept edge; only the freeze bit is kept
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl <= `VDID_CTRL_RST;
    end
    else if (avs_write && ack && avs_address == `VDID_OFS_CTRL)
    begin
      ctrl <= {31'h0000_0000, avs_writedata[`VDID_CTRL_FREEZE]};
    end
  end

endmodule : vdid_decoder

// Two flip-flop synchroniser; only the second stage is read outside
module vdid_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : vdid_sync2

/* testbench/vdid_monitor.sv */
// Purpose: Port checks for vdid_decoder
// Assumes: Two sync stages, output three edges after pins
// Notes: Bind follows the module
`timescale 1ns/1ps
module vdid_monitor (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] pixel_code,
  input wire logic register_bypass,
  input wire logic sync_in,
  input wire logic blank_in,
  input wire logic force_full_scale,
  input wire logic [14:0] therm_sink_en,
  input wire logic [3:0] lsb_switch_en,
  input wire logic sync_sink_en,
  input wire logic blank_sink_en,
  input wire logic highlight_sink_en,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_therm_shape: assert property ((therm_sink_en & (therm_sink_en + 15'h0001)) == 15'h0000)
    else $error("thermometer has a gap");
  a_sync_blank: assert property (sync_sink_en |-> blank_sink_en)
    else $error("sync without blank current");
  a_blank_zero: assert property (blank_sink_en |->
    !therm_sink_en && !lsb_switch_en && !highlight_sink_en)
    else $error("blank leaks data current");
  a_follow_ctl: assert property ($past(rstn, 4) && $past(register_bypass, 3) |->
    sync_sink_en == $past(sync_in, 3))
    else $error("bypass sync not followed");
  a_code_pass: assert property ($past(rstn, 4) && $past(register_bypass, 3) &&
    !$past(sync_in, 3) && !$past(blank_in, 3) && !$past(force_full_scale, 3) |->
    lsb_switch_en == $past(pixel_code[3:0], 3))
    else $error("bypass low nibble not followed");
  a_req_wait: assert property ($rose(avs_read) || $rose(avs_write) |-> avs_waitrequest)
    else $error("request accepted at once");
  a_wait_bound: assert property (avs_read || avs_write |-> ##[0:2] !avs_waitrequest)
    else $error("request never answered");
  a_idle_ready: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("wait while idle");
endmodule : vdid_monitor

bind vdid_decoder vdid_monitor mon (.sys_clk(sys_clk), .rstn(rstn), .pixel_code(pixel_code),
  .register_bypass(register_bypass), .sync_in(sync_in), .blank_in(blank_in), .force_full_scale(force_full_scale),
  .therm_sink_en(therm_sink_en), .lsb_switch_en(lsb_switch_en), .sync_sink_en(sync_sink_en),
  .blank_sink_en(blank_sink_en), .highlight_sink_en(highlight_sink_en), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));

/* testbench/vdid_pixel_src.sv */
// Purpose: Pixel controller model feeding vdid_decoder
// Assumes: Sample clock far slower than sys_clk
// Notes: Sample clock stands low between pixels
`timescale 1ns/1ps
module vdid_pixel_src (
  input wire logic sys_clk,
  output logic [7:0] pixel_code,
  output logic clk_p,
  output logic clk_n,
  output logic bypass,
  output logic sync_in,
  output logic blank_in,
  output logic full,
  output logic high
);
  initial
  begin
    pixel_code = 8'h00;
    {clk_p, clk_n, bypass, sync_in, blank_in, full, high} = 7'h20;
  end
  // Four-cycle phases keep data stable around the edge
  task send(input logic [7:0] c, input logic [3:0] k, input logic bp, input logic e);
    pixel_code <= c;
    {sync_in, blank_in, full, high} <= k;
    bypass <= bp;
    repeat (4) @(posedge sys_clk);
    clk_p <= e;
    clk_n <= !e;
    repeat (4) @(posedge sys_clk);
    clk_p <= 1'b0;
    clk_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask : send
endmodule : vdid_pixel_src

/* testbench/test_vdid_decoder.sv */
// Purpose: Self-checking bench for vdid_decoder
// Assumes: Pixel source model drives the video pins
// Notes: Expected values queued; a watcher compares
`timescale 1ns/1ps
module test_vdid_decoder;
  logic sys_clk = 1'b0;
  logic rstn, clk_p, clk_n, byp, s, b, f, h, so, bo, ho, avs_read, avs_write, avs_waitrequest;
  logic [7:0] pixel_code;
  logic [14:0] therm;
  logic [3:0] lsb, avs_address;
  logic [31:0] avs_writedata, avs_readdata, last, seen, r;
  logic [31:0] q[$];
  string what;
  event ev;
  int err_total = 0;
  int compares = 0;
  initial forever #50 sys_clk = ~sys_clk;
  vdid_pixel_src src (.sys_clk(sys_clk), .pixel_code(pixel_code), .clk_p(clk_p), .clk_n(clk_n), .bypass(byp),
    .sync_in(s), .blank_in(b), .full(f), .high(h));
  vdid_decoder dut (.sys_clk(sys_clk), .rstn(rstn), .pixel_code(pixel_code), .sample_clock_pair_p(clk_p),
    .sample_clock_pair_n(clk_n), .register_bypass(byp), .sync_in(s), .blank_in(b), .force_full_scale(f),
    .highlight_boost(h), .therm_sink_en(therm), .lsb_switch_en(lsb), .sync_sink_en(so), .blank_sink_en(bo),
    .highlight_sink_en(ho), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  task summarize;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  function automatic logic [31:0] exp_of(input logic [7:0] c, input logic [3:0] k);
    logic [7:0] e;
    e = (k[3] || k[2]) ? 8'h00 : (k[1] ? 8'hff : c);
    return {10'h000, 15'((16'h0001 << e[7:4]) - 16'h0001), e[3:0], k[3], k[3] | k[2], k[0] & ~k[3] & ~k[2]};
  endfunction : exp_of
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20)
    begin
      err_total++;
      summarize;
    end
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task px(input logic [7:0] c, input logic [3:0] k, input logic bp, input logic e, input logic fz);
    if ((e || bp) && !fz)
      last = exp_of(c, k);
    q.push_back(last);
    src.send(c, k, bp, e);
    seen = {10'h000, therm, lsb, so, bo, ho};
    what = "sinks";
    ->ev;
  endtask : px
  task rd(input logic [3:0] a, input logic [31:0] x, input string nm);
    q.push_back(x);
    bus(1'b0, a, 32'h0);
    seen = r;
    what = nm;
    ->ev;
  endtask : rd
  initial forever
  begin
    @ev;
    compares++;
    if (seen !== q[0])
    begin
      $display("Error %s expected %h seen %h", what, q[0], seen);
      err_total++;
    end
    void'(q.pop_front());
  end
  initial
  begin
    rstn = 1'b0;
    {avs_address, avs_read, avs_write, avs_writedata, last} = '0;
    void'($urandom(61));
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 16; i++)
      px(8'($urandom), 4'(i), 1'b0, 1'b1, 1'b0);
    px(8'hf0, 4'h0, 1'b0, 1'b1, 1'b0);
    px(8'h0f, 4'h0, 1'b0, 1'b1, 1'b0);
    px(8'ha5, 4'h1, 1'b0, 1'b1, 1'b0);
    rd(4'h4, 32'h0000_08a5, "status");
    px(8'h3c, 4'h0, 1'b0, 1'b0, 1'b0);
    bus(1'b1, 4'h0, 32'h1);
    rd(4'h0, 32'h1, "ctrl");
    px(8'h77, 4'h0, 1'b0, 1'b1, 1'b1);
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b1, 4'h4, 32'hffff_ffff);
    rd(4'h4, 32'h0000_08a5, "status ro");
    rd(4'hc, 32'h0, "unmapped");
    rd(4'h8, 32'h0000_0013, "count");
    for (int i = 0; i < 6; i++)
      px(8'($urandom), 4'($urandom), 1'b1, 1'b0, 1'b0);
    px(8'h5a, 4'h2, 1'b0, 1'b1, 1'b0);
    // Let the watcher take the last note before the verdict
    @(posedge sys_clk);
    summarize;
  end
endmodule : test_vdid_decoder
